//--- bench/lpt_apb_host.sv
// processor side model making register transfers
`timescale 1ns/100ps
module lpt_apb_host (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
            output logic e);
    int n;
    @(posedge mclk) #1;
    {psel, pwrite, paddr} = {1'b1, w, a};
    pwdata = (a == 8'h00) ? {25'h0, d[6:0]} : d;
    @(posedge mclk) #1;
    penable = 1'b1;
    n = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    // a transfer that never gets ready hands back unknowns, which every check refuses
    if (n < 16) {q, e} = {prdata, pslverr};
    else {q, e} = {33{1'bx}};
    #1;
    {psel, penable, paddr, pwdata} = {2'h0, ~paddr, ~pwdata};
  endtask : xfer
endmodule : lpt_apb_host

//--- bench/lpt_status_regs_assertions.sv
// assertions on the register port behaviour of the timer status block
`timescale 1ns/100ps
module lpt_status_regs_assertions (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [25:0] timer_configuration,
  input wire logic [2:0]  timer_control,
  input wire logic [15:0] compare_value,
  input wire logic [15:0] reload_value,
  input wire logic        event_request
);
  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence rd_status;
    psel && !penable && !pwrite && paddr == 8'h00 ##1 acc;
  endsequence
  AST_CMP_WRITE: assert property (
    wr && paddr == 8'h14 |=> compare_value == $past(pwdata[15:0]))
    else $error("compare write lost");
  AST_RLD_WRITE: assert property (
    wr && paddr == 8'h18 |=> reload_value == $past(pwdata[15:0]))
    else $error("reload write lost");
  AST_CTL_WRITE: assert property (
    wr && paddr == 8'h10 |=> timer_control == $past(pwdata[2:0]))
    else $error("control write lost");
  AST_CFG_LOCK: assert property (
    wr && paddr == 8'h0C && timer_control[0] |=> $stable(timer_configuration))
    else $error("configuration changed while running");
  AST_REQ_HOLD: assert property (
    event_request && !(wr && (paddr == 8'h04 || paddr == 8'h08)) |=> event_request)
    else $error("request dropped without clear");
  AST_STS_RSVD: assert property (
    rd_status |-> prdata[31:7] == 25'h0)
    else $error("status reserved bits not zero");
  AST_ERR_HIGH: assert property (
    acc && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access not flagged");
  AST_ERR_NONE: assert property (
    acc && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
endmodule : lpt_status_regs_assertions
bind lpt_status_regs lpt_status_regs_assertions chk (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .timer_configuration(timer_configuration), .timer_control(timer_control),
  .compare_value(compare_value), .reload_value(reload_value), .event_request(event_request));

//--- bench/test_low_power_timer_status_regs.sv
// self-checking bench of the timer status block
`timescale 1ns/100ps
module test_low_power_timer_status_regs;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, event_request, e;
  logic        encoder_mode, dir_down_event, dir_up_event, trigger_edge, timer_running, count_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] counter_in;
  int          err_count, total_checks;
  // stimulus: encoder, down, up, trigger, running, tick
  logic [5:0]  stim [7] = '{6'h30, 6'h28, 6'h04, 6'h06, 6'h10, 6'h01, 6'h01};
  logic [15:0] cnt_t [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0};
  logic [6:0]  exp_t [7] = '{7'h40, 7'h20, 7'h04, 7'h00, 7'h00, 7'h02, 7'h01};
  lpt_status_regs uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encoder_mode(encoder_mode), .dir_down_event(dir_down_event),
    .dir_up_event(dir_up_event), .trigger_edge(trigger_edge), .timer_running(timer_running),
    .counter_in(counter_in), .count_tick(count_tick), .timer_configuration(),
    .timer_control(), .compare_value(), .reload_value(), .option_select(),
    .event_request(event_request));
  lpt_apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
    check("wr_err", {31'h0, e}, 32'h0);
  endtask : wr
  task rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q, e);
    check(n, q, exp);
  endtask : rdc
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    {encoder_mode, dir_down_event, dir_up_event, trigger_edge, timer_running, count_tick} = 6'h0;
    counter_in = 16'h0;
    repeat (20) @(posedge mclk);
    #1 reset = 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk) #1;
      {encoder_mode, dir_down_event, dir_up_event, trigger_edge, timer_running,
       count_tick} = stim[i];
      counter_in = cnt_t[i];
      @(posedge mclk) #1;
      {encoder_mode, dir_down_event, dir_up_event, trigger_edge, timer_running, count_tick} = 6'h0;
      rdc("status", 8'h00, {25'h0, exp_t[i]});
      wr(8'h04, 32'h7F);
      rdc("cleared", 8'h00, 32'h0);
    end
    wr(8'h14, 32'hFFFF1234);
    rdc("compare", 8'h14, 32'h1234);
    wr(8'h0C, 32'hFFFFFFFF);
    rdc("config", 8'h0C, 32'h03FFFFFF);
    wr(8'h20, 32'hFFFFFFFF);
    rdc("option", 8'h20, 32'h3);
    wr(8'h18, 32'h5);
    rdc("done", 8'h00, 32'h18);
    wr(8'h00, 32'h0);
    rdc("readonly", 8'h00, 32'h18);
    wr(8'h04, 32'h8);
    rdc("clear_one", 8'h00, 32'h10);
    wr(8'h08, 32'h8);
    check("req_off", {31'h0, event_request}, 32'h0);
    wr(8'h08, 32'h10);
    check("req_on", {31'h0, event_request}, 32'h1);
    counter_in = 16'h5;
    fork
      wr(8'h04, 32'h2);
      begin
        repeat (2) @(posedge mclk);
        #1 count_tick = 1'b1;
        @(posedge mclk) #1 count_tick = 1'b0;
      end
    join
    rdc("set_wins", 8'h00, 32'h12);
    wr(8'h1C, 32'h9);
    rdc("counter", 8'h1C, 32'h5);
    wr(8'h10, 32'h1);
    wr(8'h08, 32'h0);
    rdc("locked", 8'h08, 32'h10);
    wr(8'h0C, 32'h0);
    rdc("cfg_locked", 8'h0C, 32'h03FFFFFF);
    rdc("unmapped", 8'h24, 32'h0);
    check("slverr", {31'h0, e}, 32'h1);
    reset = 1'b1;
    @(posedge mclk) #1 reset = 1'b0;
    check("rst_req", {31'h0, event_request}, 32'h0);
    rdc("rst_status", 8'h00, 32'h0);
    rdc("rst_reload", 8'h18, 32'h1);
    give_verdict();
  end
endmodule : test_low_power_timer_status_regs

//--- core/lpt_flag_bank.sv
// sticky event flags with write-one-to-clear and enable gating
`timescale 1ns/100ps
module lpt_flag_bank (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [6:0] set_pulse,
  input  wire logic [6:0] clear_pulse,
  input  wire logic [6:0] enable_mask,
  output logic      [6:0] flags,
  output logic            event_request
);
  logic [6:0] flags_reg;
  logic [6:0] flags_next;

  // a set in the same cycle as its clear wins
  assign flags_next = (flags_reg & ~clear_pulse) | set_pulse;
  assign flags = flags_reg;
  // request only from enabled flags
  assign event_request = |(flags_reg & enable_mask);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_reg <= lpt_pkg::RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule : lpt_flag_bank

//--- core/lpt_pkg.sv
// register map, field positions and reset values of the low power timer
package lpt_pkg;
  localparam logic [7:0]  OFS_EVENT_STATUS  = 8'h00;
  localparam logic [7:0]  OFS_EVENT_CLEAR   = 8'h04;
  localparam logic [7:0]  OFS_EVENT_ENABLE  = 8'h08;
  localparam logic [7:0]  OFS_TIMER_CONFIG  = 8'h0C;
  localparam logic [7:0]  OFS_TIMER_CONTROL = 8'h10;
  localparam logic [7:0]  OFS_COMPARE_VALUE = 8'h14;
  localparam logic [7:0]  OFS_RELOAD_VALUE  = 8'h18;
  localparam logic [7:0]  OFS_COUNTER_VALUE = 8'h1C;
  localparam logic [7:0]  OFS_OPTION_SELECT = 8'h20;
  localparam int          NUM_FLAGS         = 7;
  localparam int          BIT_DOWN          = 6;
  localparam int          BIT_UP            = 5;
  localparam int          BIT_RELOAD_DONE   = 4;
  localparam int          BIT_COMPARE_DONE  = 3;
  localparam int          BIT_TRIGGER       = 2;
  localparam int          BIT_RELOAD_MATCH  = 1;
  localparam int          BIT_COMPARE_MATCH = 0;
  localparam int          CFG_WIDTH         = 26;
  localparam int          CTRL_WIDTH        = 3;
  localparam int          OPT_WIDTH         = 2;
  localparam int          BIT_TIMER_ENABLE  = 0;
  localparam logic [6:0]  RST_FLAGS         = 7'h00;
  localparam logic [6:0]  RST_ENABLE        = 7'h00;
  localparam logic [25:0] RST_CONFIG        = 26'h0000000;
  localparam logic [2:0]  RST_CONTROL       = 3'h0;
  localparam logic [15:0] RST_COMPARE       = 16'h0000;
  localparam logic [15:0] RST_RELOAD        = 16'h0001;
  localparam logic [1:0]  RST_OPTION        = 2'h0;
endpackage : lpt_pkg

//--- core/lpt_status_regs.sv
// register file and event status logic of the low power timer
`timescale 1ns/100ps
// How it works
// - in encoder mode, direction change to down sets status bit 6
// - in encoder mode, direction change to up sets status bit 5
// - completed reload register write sets status bit 4
// - completed compare register write sets status bit 3
// - valid external trigger edge sets status bit 2
// - trigger discarded while timer runs leaves bit 2 unchanged
// - counter equal reload sets bit 1; counter equal compare sets bit 0
// - writing 1 to a clear register bit clears its flag; 0 does nothing
// - a flag raises the request only when its enable bit is set
module lpt_status_regs (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        encoder_mode,
  input  wire logic        dir_down_event,
  input  wire logic        dir_up_event,
  input  wire logic        trigger_edge,
  input  wire logic        timer_running,
  input  wire logic [15:0] counter_in,
  input  wire logic        count_tick,
  output logic      [25:0] timer_configuration,
  output logic      [2:0]  timer_control,
  output logic      [15:0] compare_value,
  output logic      [15:0] reload_value,
  output logic      [1:0]  option_select,
  output logic             event_request
);
  logic [6:0]  enable_reg;
  logic [25:0] config_reg;
  logic [2:0]  control_reg;
  logic [15:0] compare_reg;
  logic [15:0] reload_reg;
  logic [1:0]  option_reg;
  logic [15:0] counter_reg;
  logic [31:0] prdata_reg;
  logic        cmp_done_reg;
  logic        arr_done_reg;
  logic [6:0]  flags;
  logic [6:0]  set_pulse;
  logic [6:0]  clear_pulse;

  // address decode shared by every register select
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    addr_is = addr == ofs;
  endfunction : addr_is

  // match only on a counter update strobe
  function automatic logic value_match(input logic        tick,
                                       input logic [15:0] cnt,
                                       input logic [15:0] target);
    value_match = tick & (cnt == target);
  endfunction : value_match

  wire wr_access = psel & penable & pwrite;
  wire rd_setup  = psel & ~penable & ~pwrite;
  wire hit_clr   = addr_is(paddr, lpt_pkg::OFS_EVENT_CLEAR);
  wire hit_en    = addr_is(paddr, lpt_pkg::OFS_EVENT_ENABLE);
  wire hit_cfg   = addr_is(paddr, lpt_pkg::OFS_TIMER_CONFIG);
  wire hit_ctrl  = addr_is(paddr, lpt_pkg::OFS_TIMER_CONTROL);
  wire hit_cmp   = addr_is(paddr, lpt_pkg::OFS_COMPARE_VALUE);
  wire hit_arr   = addr_is(paddr, lpt_pkg::OFS_RELOAD_VALUE);
  wire hit_opt   = addr_is(paddr, lpt_pkg::OFS_OPTION_SELECT);
  wire hit_sts   = addr_is(paddr, lpt_pkg::OFS_EVENT_STATUS);
  wire hit_cnt   = addr_is(paddr, lpt_pkg::OFS_COUNTER_VALUE);
  wire mapped    = hit_sts | hit_clr | hit_en | hit_cfg | hit_ctrl | hit_cmp
                 | hit_arr | hit_cnt | hit_opt;
  wire timer_on  = control_reg[lpt_pkg::BIT_TIMER_ENABLE];

  // status register accepts no write; any write there is ignored
  wire wr_clr  = wr_access & hit_clr;
  wire wr_en   = wr_access & hit_en & ~timer_on;
  wire wr_cfg  = wr_access & hit_cfg & ~timer_on;
  wire wr_ctrl = wr_access & hit_ctrl;
  wire wr_cmp  = wr_access & hit_cmp;
  wire wr_arr  = wr_access & hit_arr;
  wire wr_opt  = wr_access & hit_opt;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_reg;

  // equality checks against the live counter value
  wire cnt_eq_arr = value_match(count_tick, counter_in, reload_reg);
  wire cnt_eq_cmp = value_match(count_tick, counter_in, compare_reg);

  assign set_pulse[lpt_pkg::BIT_DOWN]          = encoder_mode & dir_down_event;
  assign set_pulse[lpt_pkg::BIT_UP]            = encoder_mode & dir_up_event;
  assign set_pulse[lpt_pkg::BIT_RELOAD_DONE]   = arr_done_reg;
  assign set_pulse[lpt_pkg::BIT_COMPARE_DONE]  = cmp_done_reg;
  assign set_pulse[lpt_pkg::BIT_TRIGGER]       = trigger_edge & ~timer_running;
  assign set_pulse[lpt_pkg::BIT_RELOAD_MATCH]  = cnt_eq_arr;
  assign set_pulse[lpt_pkg::BIT_COMPARE_MATCH] = cnt_eq_cmp;

  // write-one-to-clear, zeros leave flags alone
  assign clear_pulse = wr_clr ? pwdata[6:0] : 7'h00;

  lpt_flag_bank u_flags (
    .mclk          (mclk),
    .reset         (reset),
    .set_pulse     (set_pulse),
    .clear_pulse   (clear_pulse),
    .enable_mask   (enable_reg),
    .flags         (flags),
    .event_request (event_request)
  );

  // read mux; reserved bits return zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (1'b1)
      hit_sts:  rd_mux = {25'h0000000, flags};
      hit_en:   rd_mux = {25'h0000000, enable_reg};
      hit_cfg:  rd_mux = {6'h00, config_reg};
      hit_ctrl: rd_mux = {29'h00000000, control_reg};
      hit_cmp:  rd_mux = {16'h0000, compare_reg};
      hit_arr:  rd_mux = {16'h0000, reload_reg};
      hit_cnt:  rd_mux = {16'h0000, counter_reg};
      hit_opt:  rd_mux = {30'h00000000, option_reg};
      default:  rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  // write-done strobes land one cycle after the write is taken
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmp_done_reg <= 1'b0;
      arr_done_reg <= 1'b0;
    end else begin
      cmp_done_reg <= wr_cmp;
      arr_done_reg <= wr_arr;
    end
  end

  // enable and configuration hold while the timer runs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_reg <= lpt_pkg::RST_ENABLE;
    end else if (wr_en) begin
      enable_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_reg <= lpt_pkg::RST_CONFIG;
    end else if (wr_cfg) begin
      config_reg <= pwdata[25:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      control_reg <= lpt_pkg::RST_CONTROL;
    end else if (wr_ctrl) begin
      control_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      compare_reg <= lpt_pkg::RST_COMPARE;
    end else if (wr_cmp) begin
      compare_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reload_reg <= lpt_pkg::RST_RELOAD;
    end else if (wr_arr) begin
      reload_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      option_reg <= lpt_pkg::RST_OPTION;
    end else if (wr_opt) begin
      option_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counter_reg <= 16'h0000;
    end else begin
      counter_reg <= counter_in;
    end
  end

  assign timer_configuration = config_reg;
  assign timer_control       = control_reg;
  assign compare_value       = compare_reg;
  assign reload_value        = reload_reg;
  assign option_select       = option_reg;
endmodule : lpt_status_regs
